/* core/phys_region_bus_config.sv */
// Physical-region bus configuration bank with applied-access decode.
`timescale 1ns/1ps
module phys_region_bus_config #(
   parameter int ADDR_W = 32
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire region_cfg_pkg::load_req_type i_load,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic i_start,
   input wire logic i_write,
   input wire logic i_burst_req,
   input wire logic i_last,
   input wire logic i_ready_n,
   input wire logic i_burst_cut_n,
   output logic [31:0] o_rd_cfg,
   output logic [31:0] o_bus_control,
   output region_cfg_pkg::access_cfg_type o_cfg,
   output logic o_pipeline_ok,
   output logic o_burst_ok,
   output logic o_parity_odd,
   output logic o_width_reserved,
   output logic o_table_loaded,
   output logic o_data_done,
   output logic o_turnaround
);
   localparam int NR = region_cfg_pkg::NUM_REGIONS;

   // Access phases, one-hot: idle, address waits, data beats, turnaround.
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ADDR = 4'h2,
      ST_DATA = 4'h4,
      ST_TURN = 4'h8
   } phase_type;

   // Region words, bus control and which words were loaded since reset.
   logic [31:0] cfg_reg [NR];
   logic [31:0] bus_control_reg_reg;
   logic [NR-1:0] loaded_reg;
   logic loaded_all_reg;
   // Access sequencing state.
   phase_type phase_reg, phase_next;
   logic [4:0] wait_reg, wait_next;
   logic [1:0] ready_s1_reg, ready_s2_reg;
   logic [region_cfg_pkg::REGION_BITS-1:0] region_reg;
   logic wr_reg;

   // Unpacks a raw configuration word into named fields.
   function automatic region_cfg_pkg::access_cfg_type unpack_cfg(
      input logic [31:0] w);
      region_cfg_pkg::access_cfg_type c;
      c.read_addr_data_waits = w[region_cfg_pkg::RAD_LO +: 5];
      c.read_data_data_waits = w[region_cfg_pkg::RDD_LO +: 2];
      c.write_addr_data_waits = w[region_cfg_pkg::WAD_LO +: 5];
      c.write_data_data_waits = w[region_cfg_pkg::WDD_LO +: 2];
      c.turnaround_waits = w[region_cfg_pkg::XDA_LO +: 4];
      c.parity_check_en = w[region_cfg_pkg::PEN_POS];
      c.parity_sense_sel = w[region_cfg_pkg::PARITY_SENSE_SEL_POS];
      c.bus_width_sel = w[region_cfg_pkg::BW_LO +: 2];
      c.read_pipeline_en = w[region_cfg_pkg::READ_PIPELINE_EN_POS];
      c.burst_access_en = w[region_cfg_pkg::BEN_POS];
      c.wait_terminate_en = w[region_cfg_pkg::WAIT_TERMINATE_EN_POS];
      return c;
   endfunction

   // Region index of an address from its top bits. While the table is not
   // valid every address maps onto the default region word instead.
   wire [3:0] addr_region =
      i_addr[ADDR_W-1 -: region_cfg_pkg::REGION_BITS];
   wire table_valid = bus_control_reg_reg[region_cfg_pkg::CTV_BIT];
   wire [3:0] sel_idx = table_valid ? addr_region
      : 4'(region_cfg_pkg::DEFAULT_REGION);

   // The region is latched for a whole access, so a control load that lands
   // in the middle of an access never switches the region word being used.
   wire [3:0] act_idx = (phase_reg == ST_IDLE) ? sel_idx : region_reg;
   wire region_cfg_pkg::access_cfg_type cur_cfg = unpack_cfg(cfg_reg[act_idx]);

   // Load strobes decoded to one bit per region word; the same bits mark
   // which words have arrived since reset.
   wire [3:0] addr_region_rd = i_load.cfg_idx;
   wire [NR-1:0] cfg_hit = i_load.cfg_we ? (NR'(1) << i_load.cfg_idx) : '0;
   wire all_loaded = &(loaded_reg | cfg_hit);
   // Bus control is accepted only once every region word is in place, so an
   // early control word cannot validate a half-loaded table.
   wire bus_control_reg_we = i_load.ctl_we && loaded_all_reg;

   // External ready/terminate are honoured only when the region enables it.
   // The pins are read after the synchroniser, so they act two cycles late.
   wire ext_ready = ready_s2_reg[0] == 1'b0;
   wire ext_cut = ready_s2_reg[1] == 1'b0;
   wire ext_ok = cur_cfg.wait_terminate_en ? (ext_ready || ext_cut)
      : 1'b1;
   wire waits_done = (wait_reg == 5'h00);
   wire beat_done = waits_done && ext_ok;

   // Wait counts loaded at the start of an access, between burst beats and
   // after the last beat.
   wire [4:0] first_waits = i_write ? cur_cfg.write_addr_data_waits
      : cur_cfg.read_addr_data_waits;
   wire [4:0] dd_waits = wr_reg ? 5'(cur_cfg.write_data_data_waits)
      : 5'(cur_cfg.read_data_data_waits);
   wire [4:0] turn_waits = 5'(cur_cfg.turnaround_waits);

   // A burst goes on only while the region allows it; a cut from the far
   // side ends it early, but only where the region honours the pins.
   wire burst_go = i_burst_req && cur_cfg.burst_access_en;
   wire cut_now = cur_cfg.wait_terminate_en && ext_cut;

   // Next values of the status outputs, decoded from the applied word and the phase so
   // that every output below comes straight from a flip-flop.
   wire pipeline_next = cur_cfg.read_pipeline_en && !wr_reg;
   wire parity_next = cur_cfg.parity_check_en
      && cur_cfg.parity_sense_sel;
   wire width_rsvd_next =
      cur_cfg.bus_width_sel == region_cfg_pkg::BW_RSVD;
   wire done_next = (phase_reg == ST_DATA) && beat_done;
   wire turn_next = (phase_next == ST_TURN);

   // One storage word per region, each written only by its own strobe bit.
   // Every word resets to the default value, so region 15 holds the word
   // that applies until a valid table has been loaded.
   for (genvar g = 0; g < NR; g++) begin : g_region
      always_ff @(posedge i_ref_clk) begin
         if (!i_rst_n) begin
            cfg_reg[g] <= region_cfg_pkg::DEFAULT_RESET;
         end else if (cfg_hit[g]) begin
            cfg_reg[g] <= i_load.data;
         end
      end
   end

   // Load flags, the all-loaded flag and the bus control register.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         bus_control_reg_reg <= region_cfg_pkg::BUS_CONTROL_REG_RESET;
         loaded_reg <= '0;
         loaded_all_reg <= 1'b0;
      end else begin
         loaded_reg <= loaded_reg | cfg_hit;
         loaded_all_reg <= all_loaded;
         if (bus_control_reg_we) begin
            bus_control_reg_reg <= i_load.data;
         end
      end
   end

   // Two-flop synchronisers for the external ready and burst-cut pins.
   // The pins come from outside the clock domain; only the second stage is
   // read by logic. Both reset to the idle high level so that no false
   // ready is seen while reset is released.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         ready_s1_reg <= 2'h3;
         ready_s2_reg <= 2'h3;
      end else begin
         ready_s1_reg <= {i_burst_cut_n, i_ready_n};
         ready_s2_reg <= ready_s1_reg;
      end
   end

   // Access phase sequencing with programmed wait-state counts.
   // A start is taken only in idle; the address phase counts the first
   // waits, each data beat needs its count at zero and, where enabled, the
   // far side's ready or burst cut, and the turnaround counts down before idle again.
   always_comb begin
      phase_next = phase_reg;
      wait_next = wait_reg;
      unique case (phase_reg)
         ST_IDLE: begin
            if (i_start) begin
               phase_next = ST_ADDR;
               wait_next = first_waits;
            end
         end
         ST_ADDR: begin
            if (waits_done) begin
               phase_next = ST_DATA;
            end else begin
               wait_next = wait_reg - 5'h01;
            end
         end
         ST_DATA: begin
            if (!waits_done) begin
               wait_next = wait_reg - 5'h01;
            end else if (beat_done) begin
               if (i_last || !burst_go || cut_now) begin
                  phase_next = ST_TURN;
                  wait_next = turn_waits;
               end else begin
                  wait_next = dd_waits;
               end
            end
         end
         ST_TURN: begin
            if (waits_done) begin
               phase_next = ST_IDLE;
            end else begin
               wait_next = wait_reg - 5'h01;
            end
         end
      endcase
   end

   // Phase state and its wait counter. The counter is loaded on entry to the
   // address and turnaround phases and between burst beats, and counts down
   // to zero, where the phase may move on.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         phase_reg <= ST_IDLE;
         wait_reg <= 5'h00;
      end else begin
         phase_reg <= phase_next;
         wait_reg <= wait_next;
      end
   end

   // Region and direction are latched when an access is taken and held to
   // its end, so the applied region cannot change between the address phase
   // and the turnaround.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         region_reg <= 4'h0;
         wr_reg <= 1'b0;
      end else if (phase_reg == ST_IDLE && i_start) begin
         region_reg <= sel_idx;
         wr_reg <= i_write;
      end
   end

   // Read-back of the region word at the load index, one cycle late, and a
   // copy of the bus control register.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_rd_cfg <= '0;
         o_bus_control <= '0;
      end else begin
         o_rd_cfg <= cfg_reg[addr_region_rd];
         o_bus_control <= bus_control_reg_reg;
      end
   end

   // Applied configuration fields; during reset they show the default word
   // so the bus starts out slow and narrow.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_cfg <= unpack_cfg(region_cfg_pkg::DEFAULT_RESET);
      end else begin
         o_cfg <= cur_cfg;
      end
   end

   // Per-access permissions and flags. Parity odd is only reported while
   // parity is enabled, so a disabled region never shows an odd sense.
   // The reserved width code is flagged rather than silently remapped.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_pipeline_ok <= 1'b0;
         o_burst_ok <= 1'b0;
         o_parity_odd <= 1'b0;
         o_width_reserved <= 1'b0;
      end else begin
         o_pipeline_ok <= pipeline_next;
         o_burst_ok <= cur_cfg.burst_access_en;
         o_parity_odd <= parity_next;
         o_width_reserved <= width_rsvd_next;
      end
   end

   // Load and phase status. The done flag is a one-cycle pulse per beat;
   // the turnaround flag stands for as long as the turnaround lasts.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_table_loaded <= 1'b0;
         o_data_done <= 1'b0;
         o_turnaround <= 1'b0;
      end else begin
         o_table_loaded <= loaded_all_reg;
         o_data_done <= done_next;
         o_turnaround <= turn_next;
      end
   end
endmodule

/* core/region_cfg_pkg.sv */
// Package with region configuration field layout, reset values and types.
package region_cfg_pkg;
   localparam int NUM_REGIONS = 16;
   localparam int REGION_BITS = 4;
   localparam int DEFAULT_REGION = 15;
   localparam int CTV_BIT = 0;
   localparam int BUS_CONTROL_REG_CTV_POS = 0;
   // Field positions in a region configuration word.
   localparam int RAD_LO = 0;
   localparam int RDD_LO = 6;
   localparam int WAD_LO = 8;
   localparam int WDD_LO = 14;
   localparam int XDA_LO = 16;
   localparam int PEN_POS = 20;
   localparam int PARITY_SENSE_SEL_POS = 21;
   localparam int BW_LO = 22;
   localparam int READ_PIPELINE_EN_POS = 24;
   localparam int BEN_POS = 28;
   localparam int WAIT_TERMINATE_EN_POS = 29;
   // Reset value of the default region word: waits 31/31/15, all else 0.
   localparam logic [31:0] DEFAULT_RESET = 32'h000f_1f1f;
   localparam logic [31:0] BUS_CONTROL_REG_RESET = 32'h0000_0000;
   localparam logic [1:0] BW_8 = 2'h0;
   localparam logic [1:0] BW_16 = 2'h1;
   localparam logic [1:0] BW_32 = 2'h2;
   localparam logic [1:0] BW_RSVD = 2'h3;

   // Decoded configuration applied to the current access.
   typedef struct packed {
      logic wait_terminate_en;
      logic burst_access_en;
      logic read_pipeline_en;
      logic [1:0] bus_width_sel;
      logic parity_sense_sel;
      logic parity_check_en;
      logic [3:0] turnaround_waits;
      logic [1:0] write_data_data_waits;
      logic [4:0] write_addr_data_waits;
      logic [1:0] read_data_data_waits;
      logic [4:0] read_addr_data_waits;
   } access_cfg_type;

   // Load port from the initialization sequencer.
   typedef struct packed {
      logic cfg_we;
      logic [3:0] cfg_idx;
      logic ctl_we;
      logic [31:0] data;
   } load_req_type;
endpackage

/* dv/ext_mem_model.sv */
// Far-side memory model that answers ready promptly or slowly.
`timescale 1ns/1ps
module ext_mem_model (
   input wire logic i_clk,
   input wire logic i_slow,
   output logic o_ready_n,
   output logic o_burst_cut_n
);
   int seed = 32'h9985c5ca;
   // Ready comes every cycle when prompt, at random when slow.
   initial o_ready_n = 1'b1;
   initial o_burst_cut_n = 1'b1;
   always @(posedge i_clk) begin
      o_ready_n <= i_slow ? 1'($random(seed)) : 1'b0;
   end
endmodule

/* dv/phys_region_bus_config_checker.sv */
// Checker of the region configuration bank ports.
`timescale 1ns/1ps
module phys_region_bus_config_checker (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire region_cfg_pkg::load_req_type i_load,
   input wire logic [31:0] o_rd_cfg,
   input wire logic [31:0] o_bus_control,
   input wire region_cfg_pkg::access_cfg_type o_cfg,
   input wire logic o_parity_odd,
   input wire logic o_width_reserved,
   input wire logic o_burst_ok,
   input wire logic o_table_loaded
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // The applied word has held still for two cycles.
   sequence s_steady;
      o_cfg == $past(o_cfg) && $past(o_cfg) == $past(o_cfg, 2);
   endsequence
   property p_bus_control_reg_rst;
      $rose(i_rst_n) |-> o_bus_control == 32'h0;
   endproperty
   a_bus_control_reg_rst: assert property (p_bus_control_reg_rst)
      else $error("control not cleared");
   property p_cfg_rst;
      $rose(i_rst_n) |-> o_cfg.read_addr_data_waits == 5'h1f &&
         o_cfg.write_addr_data_waits == 5'h1f &&
         o_cfg.turnaround_waits == 4'hf;
   endproperty
   a_cfg_rst: assert property (p_cfg_rst)
      else $error("default waits wrong");
   property p_en_rst;
      $rose(i_rst_n) |-> !o_cfg.parity_check_en && o_cfg.bus_width_sel == 2'h0
         && !o_cfg.read_pipeline_en && !o_cfg.burst_access_en
         && !o_cfg.wait_terminate_en;
   endproperty
   a_en_rst: assert property (p_en_rst)
      else $error("default enables set");
   property p_ctl_drop;
      i_load.ctl_we && !o_table_loaded ##1 !o_table_loaded
         |=> $stable(o_bus_control);
   endproperty
   a_ctl_drop: assert property (p_ctl_drop)
      else $error("early control write taken");
   property p_ctl_take;
      i_load.ctl_we && o_table_loaded
         |=> ##1 o_bus_control == $past(i_load.data, 2);
   endproperty
   a_ctl_take: assert property (p_ctl_take)
      else $error("control write lost");
   property p_parity;
      s_steady |-> o_parity_odd ==
         (o_cfg.parity_check_en && o_cfg.parity_sense_sel);
   endproperty
   a_parity: assert property (p_parity)
      else $error("parity sense wrong");
   property p_width;
      s_steady |-> o_width_reserved == (o_cfg.bus_width_sel == 2'h3);
   endproperty
   a_width: assert property (p_width)
      else $error("reserved width flag wrong");
   property p_burst;
      s_steady and o_burst_ok |-> o_cfg.burst_access_en;
   endproperty
   a_burst: assert property (p_burst)
      else $error("burst without enable");
   property p_readback;
      i_load.cfg_we ##1 (!i_load.cfg_we && $stable(i_load.cfg_idx))
         |=> o_rd_cfg == $past(i_load.data, 2);
   endproperty
   a_readback: assert property (p_readback)
      else $error("region word not stored");
endmodule
bind phys_region_bus_config phys_region_bus_config_checker i_chk (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_load(i_load),
   .o_rd_cfg(o_rd_cfg), .o_bus_control(o_bus_control), .o_cfg(o_cfg),
   .o_parity_odd(o_parity_odd), .o_width_reserved(o_width_reserved),
   .o_burst_ok(o_burst_ok), .o_table_loaded(o_table_loaded)
);

/* dv/tb.sv */
// Testbench for the region configuration bank.
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   region_cfg_pkg::load_req_type ld_r = '0;
   logic [31:0] addr = 32'h0;
   logic start = 1'b0;
   logic wr = 1'b0;
   logic slow = 1'b0;
   logic burst_req = 1'b0;
   logic last = 1'b0;
   logic pipe_ok, burst_ok, par_odd, wd_rsvd, tbl_ld, turn;
   logic ready_n, cut_n, done;
   logic [31:0] rd_cfg, bus_ctl;
   region_cfg_pkg::access_cfg_type cfg;
   logic [31:0] word [16];
   int seed = 32'h9985c5ca;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   phys_region_bus_config i_phys_region_bus_config (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_load(ld_r), .i_addr(addr),
      .i_start(start), .i_write(wr), .i_burst_req(burst_req),
      .i_last(last), .i_ready_n(ready_n), .i_burst_cut_n(cut_n),
      .o_rd_cfg(rd_cfg), .o_bus_control(bus_ctl), .o_cfg(cfg),
      .o_pipeline_ok(pipe_ok), .o_burst_ok(burst_ok),
      .o_parity_odd(par_odd), .o_width_reserved(wd_rsvd),
      .o_table_loaded(tbl_ld), .o_data_done(done), .o_turnaround(turn));
   ext_mem_model i_ext_mem_model (
      .i_clk(clk), .i_slow(slow), .o_ready_n(ready_n),
      .o_burst_cut_n(cut_n));
   // Clock and a cycle ceiling against hangs.
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
   // Unpacks a region word into the applied fields.
   function automatic region_cfg_pkg::access_cfg_type to_cfg(
      input logic [31:0] w);
      return {w[29], w[28], w[24], w[23:22], w[21], w[20], w[19:16],
         w[15:14], w[12:8], w[7:6], w[4:0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic ld(input logic cw, input logic [3:0] ix,
      input logic [31:0] d);
      @(negedge clk);
      ld_r.cfg_we = cw;
      ld_r.ctl_we = !cw;
      ld_r.cfg_idx = ix;
      ld_r.data = d;
      @(negedge clk);
      ld_r.cfg_we = 1'b0;
      ld_r.ctl_we = 1'b0;
   endtask
   // One access: first beat, an optional second burst beat, turnaround.
   task automatic acc(input logic [3:0] r, input logic [31:0] w);
      int n;
      int m;
      logic multi;
      logic exact;
      n = 0;
      m = 0;
      @(negedge clk);
      addr = {r, 28'($random(seed))};
      wr = 1'($random(seed));
      burst_req = 1'($random(seed));
      last = 1'b0;
      multi = burst_req && w[28];
      exact = !slow || !w[29];
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      while (done !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk("done", 32'(done), 32'h1);
      if (exact) begin
         chk("addr_waits", n, 32'(wr ? w[12:8] : w[4:0]) + 32'h2);
      end
      last = 1'b1;
      if (multi) begin
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (done !== 1'b1 && n < 300);
         chk("burst_done", 32'(done), 32'h1);
         if (exact) begin
            chk("data_waits", n, 32'(wr ? w[15:14] : w[7:6]) + 32'h1);
         end
      end
      chk("cfg", 32'(cfg), 32'(to_cfg(w)));
      chk("pipeline", 32'(pipe_ok), 32'(w[24] && !wr));
      chk("burst_ok", 32'(burst_ok), 32'(w[28]));
      chk("parity_odd", 32'(par_odd), 32'(w[20] && w[21]));
      chk("width_rsvd", 32'(wd_rsvd), 32'(w[23:22] == 2'h3));
      while (turn === 1'b1 && m < 40) begin
         @(negedge clk);
         m++;
      end
      chk("turn_waits", m, 32'(w[19:16]) + 32'h1);
      repeat (4) @(negedge clk);
   endtask
   // Loads all region words, then the control word, then accesses.
   task automatic run(input logic [31:0] ctl, input logic sl);
      slow = sl;
      for (int k = 0; k < 16; k++) begin
         word[k] = $random(seed) & 32'h317f_ffff;
         if (k == 3) word[k][23:22] = 2'h3;
         ld(1'b1, 4'(k), word[k]);
         repeat (2) @(negedge clk);
         chk("rd_cfg", rd_cfg, word[k]);
      end
      chk("loaded", 32'(tbl_ld), 32'h1);
      ld(1'b0, 4'h0, ctl);
      repeat (2) @(negedge clk);
      chk("bus_ctl", bus_ctl, ctl);
      for (int k = 0; k < 16; k++) acc(4'(k), ctl[0] ? word[k] : word[15]);
   endtask
   task automatic close_out();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Reset, early control write, valid table, second reset, invalid table.
   initial begin
      ld_r.cfg_idx = 4'hf;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk("rd_cfg", rd_cfg, region_cfg_pkg::DEFAULT_RESET);
      chk("cfg", 32'(cfg), 32'(to_cfg(region_cfg_pkg::DEFAULT_RESET)));
      chk("loaded", 32'(tbl_ld), 32'h0);
      ld(1'b0, 4'h0, 32'h1);
      repeat (2) @(negedge clk);
      chk("bus_ctl", bus_ctl, 32'h0);
      run(32'h1, 1'b0);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      run(32'h0, 1'b1);
      close_out();
   end
endmodule
